//--- design/eac_map.svh
// register offsets, field positions and timing figures of the nonvolatile access block
`ifndef EAC_MAP_SVH
`define EAC_MAP_SVH
`define EAC_OFF_ADDR_LOW 6'h21
`define EAC_OFF_ADDR_HIGH 6'h22
`define EAC_OFF_DATA 6'h20
`define EAC_OFF_CONTROL 6'h1f
`define EAC_BIT_READ 0
`define EAC_BIT_STROBE 1
`define EAC_BIT_MASTER 2
`define EAC_BIT_IRQ_EN 3
`define EAC_BIT_MODE_LO 4
`define EAC_BIT_MODE_HI 5
`define EAC_ADDR_HI_BIT 8
`define EAC_MASTER_CYCLES 3'h4
`define EAC_WRITE_STALL 3'h2
`define EAC_READ_STALL 3'h4
`define EAC_RC_CYCLES_ATOMIC 32'd26368
`define EAC_RC_CYCLES_SPLIT 32'd14222
`define EAC_RC_TICK_DIV 32'd25
`endif

//--- design/eac_pkg.sv
// types of the nonvolatile access block
package eac_pkg;
   typedef enum logic [1:0] {
      EAC_MODE_ATOMIC = 2'b00,
      EAC_MODE_ERASE = 2'b01,
      EAC_MODE_WRITE = 2'b10,
      EAC_MODE_RSVD = 2'b11
   } eac_mode_t;
   typedef enum logic [1:0] {
      EAC_ST_IDLE = 2'b00,
      EAC_ST_PROG = 2'b01
   } eac_state_t;
endpackage

//--- design/eac_prog_timer.sv
// programming timer counted in calibrated-oscillator ticks
`timescale 1ns/1ps
`include "eac_map.svh"
module eac_prog_timer
   import eac_pkg::*;
#(
   parameter logic [31:0] RC_DIV = `EAC_RC_TICK_DIV,
   parameter logic [31:0] ATOMIC_TICKS = `EAC_RC_CYCLES_ATOMIC,
   parameter logic [31:0] SPLIT_TICKS = `EAC_RC_CYCLES_SPLIT
) (
   input wire logic core_clk,
   input wire logic rst_sync_n,
   input wire logic start,
   input eac_mode_t mode,
   output logic done
);
   logic [31:0] div_reg;
   logic [31:0] ticks_reg;
   logic running_reg;
   // divider stands in for the calibrated oscillator period
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         div_reg <= 32'h0;
      end else if (start || div_reg == RC_DIV - 32'h1) begin
         div_reg <= 32'h0;
      end else begin
         div_reg <= div_reg + 32'h1;
      end
   end
   // tick countdown; atomic takes the long figure
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ticks_reg <= 32'h0;
         running_reg <= 1'b0;
      end else if (start) begin
         ticks_reg <= (mode == EAC_MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;
         running_reg <= 1'b1;
      end else if (running_reg && div_reg == RC_DIV - 32'h1) begin
         if (ticks_reg <= 32'h1) begin
            running_reg <= 1'b0;
         end
         ticks_reg <= ticks_reg - 32'h1;
      end
   end
   assign done = running_reg && div_reg == RC_DIV - 32'h1 && ticks_reg <= 32'h1;
endmodule // eac_prog_timer

//--- design/eac_access_ctrl.sv
// register-level access controller for the data nonvolatile array
// Summary of operation
// - reserved address bits 15..9 and control bits 7..6 read as zero
// - byte address is bits 8..0, array addressed linearly from zero
// - data byte supplies write data and receives read data
// - mode 00 atomic, 01 erase, 10 write only, 11 reserved
// - mode writes ignored while programming is under way
// - reset clears mode unless programming is still busy
// - ready interrupt is a level while strobe clear, enable and global flag set and flash self-programming disabled
// - master enable clears itself four cycles after being set
// - strobe starts programming only while master enable is still set
// - strobe stays set for the programming time, then clears itself
// - setting the strobe stalls the cpu two cycles
// - read strobe fetches the byte at once and stalls the cpu four cycles
// - during a write, reads are refused and address changes blocked
// - programming time counted as 26368 calibrated oscillator cycles in atomic mode, 14222 in the other modes
`timescale 1ns/1ps
`include "eac_map.svh"
module eac_access_ctrl
   import eac_pkg::*;
#(
   parameter int ADDR_W = 9,
   parameter int DEPTH = 512,
   parameter logic [31:0] RC_DIV = `EAC_RC_TICK_DIV,
   parameter logic [31:0] ATOMIC_TICKS = `EAC_RC_CYCLES_ATOMIC,
   parameter logic [31:0] SPLIT_TICKS = `EAC_RC_CYCLES_SPLIT
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [5:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [7:0] io_rdata,
   input wire logic global_irq_enable,
   input wire logic flash_selfprog_enable,
   output logic ready_irq,
   output logic cpu_stall
);
   logic rst_meta_reg;
   logic rst_sync_n;
   logic busy_reg;
   logic [7:0] array_mem [DEPTH];
   logic [ADDR_W-1:0] nv_byte_address_reg;
   logic [7:0] nv_data_byte_reg;
   eac_mode_t mode_reg;
   logic irq_en_reg;
   logic master_reg;
   logic [2:0] master_cnt_reg;
   logic [2:0] stall_reg;
   logic wr_ctl;
   logic start_prog;
   logic start_read;
   logic prog_done;
   logic timer_rst_n;
   logic [7:0] erase_val;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   assign wr_ctl = io_wr && io_addr == `EAC_OFF_CONTROL;
   assign start_prog = wr_ctl && io_wdata[`EAC_BIT_STROBE] && master_reg && !busy_reg
      && !flash_selfprog_enable;
   assign start_read = wr_ctl && io_wdata[`EAC_BIT_READ] && !busy_reg;
   assign erase_val = 8'hff;

   // busy flag doubles as the strobe bit; it survives reset so a write completes
   always_ff @(posedge core_clk) begin
      if (start_prog) begin
         busy_reg <= 1'b1;
      end else if (prog_done) begin
         busy_reg <= 1'b0;
      end else if (!rst_sync_n) begin
         // only a live write survives; an unknown power-up state counts as idle
         case (busy_reg)
            1'b1: busy_reg <= 1'b1;
            default: busy_reg <= 1'b0;
         endcase
      end
   end

   // timer resets with the block unless a write is still running
   assign timer_rst_n = rst_sync_n || busy_reg;

   eac_prog_timer #(
      .RC_DIV(RC_DIV),
      .ATOMIC_TICKS(ATOMIC_TICKS),
      .SPLIT_TICKS(SPLIT_TICKS)
   ) u_timer (
      .core_clk(core_clk),
      .rst_sync_n(timer_rst_n),
      .start(start_prog),
      .mode(mode_reg),
      .done(prog_done)
   );

   // address register: no reset value, frozen while programming
   always_ff @(posedge core_clk) begin
      if (io_wr && !busy_reg && io_addr == `EAC_OFF_ADDR_LOW) begin
         nv_byte_address_reg[7:0] <= io_wdata;
      end else if (io_wr && !busy_reg && io_addr == `EAC_OFF_ADDR_HIGH) begin
         nv_byte_address_reg[`EAC_ADDR_HI_BIT] <= io_wdata[0];
      end
   end

   // data byte: software load or read fetch
   always_ff @(posedge core_clk) begin
      if (start_read) begin
         nv_data_byte_reg <= array_mem[nv_byte_address_reg];
      end else if (io_wr && io_addr == `EAC_OFF_DATA) begin
         nv_data_byte_reg <= io_wdata;
      end
   end

   // array update lands at the end of programming time
   always_ff @(posedge core_clk) begin
      if (prog_done) begin
         case (mode_reg)
            EAC_MODE_ATOMIC: array_mem[nv_byte_address_reg] <= nv_data_byte_reg;
            EAC_MODE_ERASE: array_mem[nv_byte_address_reg] <= erase_val;
            EAC_MODE_WRITE: begin
               array_mem[nv_byte_address_reg] <= array_mem[nv_byte_address_reg]
                  & nv_data_byte_reg;
            end
            default: begin
            end
         endcase
      end
   end

   // mode field: reset to atomic only when idle
   always_ff @(posedge core_clk) begin
      if (!rst_sync_n) begin
         if (!busy_reg) begin
            mode_reg <= EAC_MODE_ATOMIC;
         end
      end else if (wr_ctl && !busy_reg) begin
         mode_reg <= eac_mode_t'(io_wdata[`EAC_BIT_MODE_HI:`EAC_BIT_MODE_LO]);
      end
   end

   // interrupt enable
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_en_reg <= 1'b0;
      end else if (wr_ctl) begin
         irq_en_reg <= io_wdata[`EAC_BIT_IRQ_EN];
      end
   end

   // master enable times out so a stray write cannot program
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         master_reg <= 1'b0;
         master_cnt_reg <= 3'h0;
      end else if (wr_ctl && io_wdata[`EAC_BIT_MASTER] && !io_wdata[`EAC_BIT_STROBE]) begin
         master_reg <= 1'b1;
         master_cnt_reg <= `EAC_MASTER_CYCLES;
      end else if (master_reg) begin
         if (master_cnt_reg == 3'h1 || start_prog) begin
            master_reg <= 1'b0;
         end
         master_cnt_reg <= master_cnt_reg - 3'h1;
      end
   end

   // cpu stall counter
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         stall_reg <= 3'h0;
      end else if (start_prog) begin
         stall_reg <= `EAC_WRITE_STALL;
      end else if (start_read) begin
         stall_reg <= `EAC_READ_STALL;
      end else if (stall_reg != 3'h0) begin
         stall_reg <= stall_reg - 3'h1;
      end
   end
   assign cpu_stall = stall_reg != 3'h0;

   // level interrupt only when idle and no flash programming
   assign ready_irq = irq_en_reg && global_irq_enable && !busy_reg
      && !flash_selfprog_enable;

   // read mux; reserved bits zero
   always_comb begin
      io_rdata = 8'h00;
      if (io_rd) begin
         case (io_addr)
            `EAC_OFF_ADDR_LOW: io_rdata = nv_byte_address_reg[7:0];
            `EAC_OFF_ADDR_HIGH: io_rdata = {7'h00, nv_byte_address_reg[`EAC_ADDR_HI_BIT]};
            `EAC_OFF_DATA: io_rdata = nv_data_byte_reg;
            `EAC_OFF_CONTROL: io_rdata = {2'b00, mode_reg, irq_en_reg, master_reg,
               busy_reg, 1'b0};
            default: io_rdata = 8'h00;
         endcase
      end
   end

   // master enable lapses within four cycles of being set
   property p_master_expires;
      @(posedge core_clk) disable iff (!rst_sync_n)
      $rose(master_reg) |-> ##[1:4] !master_reg;
   endproperty
   a_master_expires: assert property (p_master_expires)
      else $error("master enable stuck");

   // strobe alone never starts a write
   property p_no_start_without_master;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (wr_ctl && io_wdata[`EAC_BIT_STROBE] && !master_reg && !busy_reg) |=> !busy_reg;
   endproperty
   a_no_start_without_master: assert property (p_no_start_without_master)
      else $error("strobe took effect without master");

   // write start halts the cpu exactly two cycles
   property p_write_stall;
      @(posedge core_clk) disable iff (!rst_sync_n)
      start_prog |=> cpu_stall [*2] ##1 !cpu_stall;
   endproperty
   a_write_stall: assert property (p_write_stall)
      else $error("write stall length wrong");

   // read fetch halts the cpu exactly four cycles
   property p_read_stall;
      @(posedge core_clk) disable iff (!rst_sync_n)
      start_read |=> cpu_stall [*4] ##1 !cpu_stall;
   endproperty
   a_read_stall: assert property (p_read_stall)
      else $error("read stall length wrong");

   // no ready interrupt while programming
   property p_irq_quiet_busy;
      @(posedge core_clk) disable iff (!rst_sync_n)
      busy_reg |-> !ready_irq;
   endproperty
   a_irq_quiet_busy: assert property (p_irq_quiet_busy)
      else $error("irq while programming");

   // mode field frozen through a write
   property p_mode_frozen;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (busy_reg && $past(busy_reg)) |-> $stable(mode_reg);
   endproperty
   a_mode_frozen: assert property (p_mode_frozen)
      else $error("mode changed while busy");

   // address frozen through a write
   property p_addr_frozen;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (busy_reg && $past(busy_reg)) |-> $stable(nv_byte_address_reg);
   endproperty
   a_addr_frozen: assert property (p_addr_frozen)
      else $error("address changed while busy");

   // strobe stays up well past the start; full length is far above eight cycles
   property p_busy_holds;
      @(posedge core_clk) disable iff (!rst_sync_n)
      start_prog |=> busy_reg [*8];
   endproperty
   a_busy_holds: assert property (p_busy_holds)
      else $error("strobe dropped early");

   // reserved control bits read as zero
   property p_reserved_zero;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (io_rd && io_addr == `EAC_OFF_CONTROL) |-> io_rdata[7:6] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits set");

   // reserved address bits read as zero
   property p_addr_high_zero;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (io_rd && io_addr == `EAC_OFF_ADDR_HIGH) |-> io_rdata[7:1] == 7'h00;
   endproperty
   a_addr_high_zero: assert property (p_addr_high_zero)
      else $error("reserved address bits set");

   // an idle reset leaves atomic mode; watched through reset, so no disable
   property p_mode_reset_idle;
      @(posedge core_clk)
      ($past(!rst_sync_n) && !$past(busy_reg)) |-> mode_reg == EAC_MODE_ATOMIC;
   endproperty
   a_mode_reset_idle: assert property (p_mode_reset_idle)
      else $error("mode kept through idle reset");

   // end of a write raises the ready level when enabled
   property p_irq_on_ready;
      @(posedge core_clk) disable iff (!rst_sync_n)
      ($fell(busy_reg) && irq_en_reg && global_irq_enable && !flash_selfprog_enable)
         |-> ready_irq;
   endproperty
   a_irq_on_ready: assert property (p_irq_on_ready)
      else $error("no ready irq after write");

   // a started write consumes the master enable
   property p_master_used;
      @(posedge core_clk) disable iff (!rst_sync_n)
      start_prog |=> !master_reg;
   endproperty
   a_master_used: assert property (p_master_used)
      else $error("master enable left after start");

   // a refused read leaves the data byte alone
   property p_read_refused;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (busy_reg && wr_ctl && io_wdata[`EAC_BIT_READ]) |=> $stable(nv_data_byte_reg);
   endproperty
   a_read_refused: assert property (p_read_refused)
      else $error("read taken while busy");

   // no stall appears without a start
   property p_stall_idle;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (!start_prog && !start_read && !cpu_stall) |=> !cpu_stall;
   endproperty
   a_stall_idle: assert property (p_stall_idle)
      else $error("stall without access");

   // master enable only rises from a control write
   property p_master_from_write;
      @(posedge core_clk) disable iff (!rst_sync_n)
      $rose(master_reg) |-> $past(wr_ctl);
   endproperty
   a_master_from_write: assert property (p_master_from_write)
      else $error("master enable rose by itself");

   // main scenarios
   c_write: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      start_prog);
   c_done: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      prog_done);
   c_read: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      start_read);
   c_irq: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      $rose(ready_irq));
   c_reset_busy: cover property (@(posedge core_clk)
      !rst_sync_n && busy_reg);
endmodule // eac_access_ctrl

//--- verification/tb.sv
// self-checking testbench of the nonvolatile access controller
`timescale 1ns/1ps
`include "eac_map.svh"
module tb;
   import eac_pkg::*;
   // short timer figures: atomic write 40 cycles, split 20 cycles
   localparam int DIV = 2;
   localparam int AT = 20;
   localparam int SP = 10;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] io_addr = 6'h00;
   logic [7:0] io_wdata = 8'h00;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_rdata;
   logic global_irq_enable = 1'b1;
   logic flash_selfprog_enable = 1'b0;
   logic ready_irq;
   logic cpu_stall;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int prog_cyc = 0;
   int stall_cnt = 0;
   int stall_last = 0;
   int stall_runs = 0;
   eac_access_ctrl #(.RC_DIV(DIV), .ATOMIC_TICKS(AT), .SPLIT_TICKS(SP)) u_eac_access_ctrl (
      .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
      .global_irq_enable(global_irq_enable), .flash_selfprog_enable(flash_selfprog_enable),
      .ready_irq(ready_irq), .cpu_stall(cpu_stall));
   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;
   // cycle count and length of the last finished stall run
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cpu_stall === 1'b1) begin
         stall_cnt <= stall_cnt + 1;
      end else if (stall_cnt != 0) begin
         stall_runs <= stall_runs + 1;
         stall_last <= stall_cnt;
         stall_cnt <= 0;
      end
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // called at a falling edge; held through the taking rising edge, then one idle cycle
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge core_clk);
      io_wr = 1'b0;
      @(negedge core_clk);
   endtask
   // read data taken at the rising edge while the select still stands
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      io_addr = a;
      io_rd = 1'b1;
      @(posedge core_clk);
      d = io_rdata;
      @(negedge core_clk);
      io_rd = 1'b0;
      @(negedge core_clk);
   endtask
   // length of the stall run that ends after this call; 0 if none
   task automatic stall_len(output int n);
      int r0;
      r0 = stall_runs;
      repeat (5) @(negedge core_clk);
      n = (stall_runs == r0 + 1) ? stall_last : 0;
   endtask
   task automatic set_addr(input logic [8:0] a);
      wr(`EAC_OFF_ADDR_HIGH, {7'h00, a[8]});
      wr(`EAC_OFF_ADDR_LOW, a[7:0]);
   endtask
   // interrupts off, selfprog held low, master then strobe two cycles apart
   task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
      int n;
      global_irq_enable = 1'b0;
      set_addr(a);
      wr(`EAC_OFF_DATA, d);
      wr(`EAC_OFF_CONTROL, {2'b00, m, 4'b0100});
      wr(`EAC_OFF_CONTROL, {2'b00, m, 4'b0010});
      prog_cyc = cyc - 1;
      stall_len(n);
      chk("write stall", 8'(n), 8'd2);
      global_irq_enable = 1'b1;
   endtask
   // cycles from the strobe edge until a poll sees the strobe clear
   task automatic wait_idle(output int n);
      logic [7:0] v;
      int k;
      k = 0;
      do begin
         rd(`EAC_OFF_CONTROL, v);
         k++;
      end while (v[1] === 1'b1 && k < 200);
      n = cyc - prog_cyc;
   endtask
   task automatic fetch(input logic [8:0] a, output logic [7:0] d);
      int n;
      set_addr(a);
      wr(`EAC_OFF_CONTROL, 8'h01);
      stall_len(n);
      chk("read stall", 8'(n), 8'd4);
      rd(`EAC_OFF_DATA, d);
   endtask
   task automatic do_reset(input int k);
      rst_n = 1'b0;
      repeat (k) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
   endtask
   // reserved bits of the high address byte and of control read as zero
   task automatic t_reserved;
      logic [7:0] v;
      wr(`EAC_OFF_ADDR_HIGH, 8'hff);
      rd(`EAC_OFF_ADDR_HIGH, v);
      chk("addr high", v, 8'h01);
      wr(`EAC_OFF_CONTROL, 8'hc8);
      rd(`EAC_OFF_CONTROL, v);
      chk("ctl reserved", v, 8'h08);
   endtask
   // atomic write, with refused accesses while busy, then read back
   task automatic t_atomic;
      logic [7:0] v;
      int n;
      prog(9'h1a5, 8'h3c, 2'b00);
      wr(`EAC_OFF_ADDR_LOW, 8'h00);
      wr(`EAC_OFF_CONTROL, 8'h39);
      rd(`EAC_OFF_ADDR_LOW, v);
      chk("addr while busy", v, 8'ha5);
      rd(`EAC_OFF_DATA, v);
      chk("data after refused read", v, 8'h3c);
      rd(`EAC_OFF_CONTROL, v);
      chk("ctl while busy", v, 8'h0a);
      chk("irq while busy", {7'h00, ready_irq}, 8'h01 ^ 8'h01);
      wait_idle(n);
      chk("atomic time", 8'(n >= AT * DIV + 1 && n <= AT * DIV + 3), 8'h01);
      chk("irq when idle", {7'h00, ready_irq}, 8'h01);
      flash_selfprog_enable = 1'b1;
      @(negedge core_clk);
      chk("irq in selfprog", {7'h00, ready_irq}, 8'h00);
      global_irq_enable = 1'b0;
      flash_selfprog_enable = 1'b0;
      @(negedge core_clk);
      chk("irq global off", {7'h00, ready_irq}, 8'h00);
      global_irq_enable = 1'b1;
      @(negedge core_clk);
      fetch(9'h1a5, v);
      chk("atomic cell", v, 8'h3c);
      fetch(9'h0a5, v);
      chk("other cell", v === 8'h3c ? 8'h00 : 8'h01, 8'h01);
   endtask
   // strobe without master, and after the master enable has expired
   task automatic t_master;
      logic [7:0] v;
      wr(`EAC_OFF_CONTROL, 8'h02);
      rd(`EAC_OFF_CONTROL, v);
      chk("strobe no master", v, 8'h00);
      wr(`EAC_OFF_CONTROL, 8'h04);
      rd(`EAC_OFF_CONTROL, v);
      chk("master set", v, 8'h04);
      @(negedge core_clk);
      wr(`EAC_OFF_CONTROL, 8'h02);
      chk("stall after expiry", {7'h00, cpu_stall}, 8'h00);
      rd(`EAC_OFF_CONTROL, v);
      chk("strobe after expiry", v, 8'h00);
   endtask
   // erase, write-only and reserved modes on one cell
   task automatic t_modes;
      logic [1:0] m[3] = '{2'b01, 2'b10, 2'b11};
      logic [7:0] d[3] = '{8'h00, 8'h0f, 8'h00};
      logic [7:0] e[3] = '{8'hff, 8'h0f, 8'h0f};
      logic [7:0] v;
      int n;
      for (int i = 0; i < 3; i++) begin
         prog(9'h1a5, d[i], m[i]);
         wait_idle(n);
         chk("split time", 8'(n >= SP * DIV + 1 && n <= SP * DIV + 3), 8'h01);
         fetch(9'h1a5, v);
         chk("mode cell", v, e[i]);
      end
   endtask
   // reset keeps mode and strobe while busy, clears mode when idle
   task automatic t_reset;
      logic [7:0] v;
      int n;
      prog(9'h011, 8'h55, 2'b10);
      do_reset(3);
      rd(`EAC_OFF_CONTROL, v);
      chk("ctl after busy reset", v, 8'h22);
      wait_idle(n);
      chk("write through reset", 8'(n >= SP * DIV + 1 && n <= SP * DIV + 3), 8'h01);
      wr(`EAC_OFF_CONTROL, 8'h10);
      do_reset(3);
      rd(`EAC_OFF_CONTROL, v);
      chk("ctl after idle reset", v, 8'h00);
   endtask
   // main sequence
   initial begin
      do_reset(5);
      t_reserved();
      t_atomic();
      t_master();
      t_modes();
      t_reset();
      results();
   end
   // watchdog well beyond the few hundred cycles the tests take
   initial begin
      #20000;
      n_errors++;
      results();
   end
endmodule // tb
